// [hw/baro_cmd_port.sv]
// two-wire slave command port with calibration memory and conversion control
// How it works
// RL1 - start opens and stop closes every message; only framed bytes count
// RL2 - answer address 111011 plus inverted chip select, then read/write bit
// RL3 - reset command is taken at any moment, aborting conversions and reads
// RL4 - master recovers a stuck acknowledge with extra clocks then reset
// RL5 - memory read: write carries command, then separate read fetches the word
// RL6 - memory word sent high byte first; master acks then nacks then stops
// RL7 - conversion command makes the port busy until the converter finishes
// RL8 - result read command, then three result bytes follow on read
// RL9 - every byte is followed by an acknowledge before the next is sent
// RL10 - calibration memory is 128 bits and carries a 4-bit check code
// RL11 - word 0 is reserved factory data, not a coefficient
// RL12 - words 1 to 6 are coefficients; word 7 holds check code in low nibble
// RL13 - memory read command 0xA0..0xAE carries word address in bits 3..1
// RL14 - 0x40..0x48 pressure, 0x50..0x58 temperature; oversampling in bits 3..1
// RL15 - result read gives zero if none, repeated or mid-conversion; overlap corrupts
// RL16 - master sends reset once after power-on to load calibration storage
module baro_cmd_port #(
  parameter logic [baro_port_pkg::CAL_WORDS-1:0][baro_port_pkg::CAL_WORD_W-1:0] CAL_IMAGE =
    {16'h0007, 16'h0006, 16'h0005, 16'h0004, 16'h0003, 16'h0002, 16'h0001, 16'h0000},
  parameter logic [baro_port_pkg::CHECK_CODE_W-1:0] CHECK_CODE = 4'h0
) (
  input  wire logic                                  clock_i,
  input  wire logic                                  rst_n_i,
  input  wire logic                                  scl_i,
  input  wire logic                                  sda_i,
  output logic                                       sda_o,
  output logic                                       sda_oe_o,
  input  wire logic                                  chip_select_pin_i,
  input  wire logic                                  protocol_select_pin_i,
  output baro_port_pkg::conv_req_t                   conv_o,
  input  wire logic                                  conv_done_i,
  input  wire logic [baro_port_pkg::RESULT_W-1:0]    conv_result_i,
  output logic                                       busy_o
);

  baro_port_pkg::port_regs_t q;
  baro_port_pkg::port_regs_t d;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      bus_start;
  logic                      bus_stop;
  logic                      addr_match;
  logic                      exec;
  logic [7:0]                next_byte;
  logic [1:0]                next_idx;

  function automatic logic [7:0] pick(input logic [baro_port_pkg::RESULT_W-1:0] w,
                                      input logic [1:0] i);
    logic [7:0] b;
    case (i)
      2'h0:    b = w[23:16];
      2'h1:    b = w[15:8];
      2'h2:    b = w[7:0];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  always_comb begin
    d         = q;
    exec      = 1'b0;
    next_byte = 8'h00;
    next_idx  = q.byte_idx;
    d.conv.start = 1'b0;
    // two-flop synchronisers on every pin; only stage 1 is read by logic
    d.scl_sync = {q.scl_sync[0], scl_i};
    d.sda_sync = {q.sda_sync[0], sda_i};
    d.cs_sync  = {q.cs_sync[0], chip_select_pin_i};
    d.psel_sync = {q.psel_sync[0], protocol_select_pin_i};
    d.scl_prev = q.scl_sync[1];
    d.sda_prev = q.sda_sync[1];
    scl_rise   = q.scl_sync[1] & ~q.scl_prev;
    scl_fall   = ~q.scl_sync[1] & q.scl_prev;
    bus_start  = q.scl_sync[1] & q.scl_prev & ~q.sda_sync[1] & q.sda_prev;
    bus_stop   = q.scl_sync[1] & q.scl_prev & q.sda_sync[1] & ~q.sda_prev;
    addr_match = (q.sh[7:2] == baro_port_pkg::DEV_ADDR_HI) &&
                 (q.sh[1] == ~q.cs_sync[1]);                                  // [RL2]

    // converter finishing; an overlapped command leaves a wrong result
    if (conv_done_i && q.busy) begin                                          // [RL7]
      d.busy         = 1'b0;
      d.result       = q.corrupt ? ~conv_result_i : conv_result_i;            // [RL15]
      d.result_valid = 1'b1;
      d.corrupt      = 1'b0;
    end

    case (q.st)
      baro_port_pkg::ST_IDLE: begin
        d.drive = 1'b0;
      end
      baro_port_pkg::ST_ADDR, baro_port_pkg::ST_CMD: begin
        if (scl_rise) begin
          d.sh  = {q.sh[6:0], q.sda_sync[1]};
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == baro_port_pkg::BITS_PER_BYTE - 4'h1) begin
            d.st = (q.st == baro_port_pkg::ST_ADDR) ? baro_port_pkg::ST_ADDR_ACK
                                                    : baro_port_pkg::ST_CMD_ACK;
          end
        end
      end
      baro_port_pkg::ST_ADDR_ACK: begin
        if (scl_fall) begin
          if (addr_match) begin                                               // [RL2]
            d.drive = 1'b1;
            d.rd    = q.sh[0];
            d.st    = baro_port_pkg::ST_ACK_HOLD;
          end else begin
            d.st = baro_port_pkg::ST_IGNORE;
          end
        end
      end
      baro_port_pkg::ST_CMD_ACK: begin
        if (scl_fall) begin
          d.drive = 1'b1;
          exec    = 1'b1;
          d.st    = baro_port_pkg::ST_ACK_HOLD;
        end
      end
      baro_port_pkg::ST_ACK_HOLD: begin
        if (scl_fall) begin
          d.drive = 1'b0;
          d.cnt   = 4'h0;
          if (q.rd) begin
            // first byte goes out on the same falling edge that ends the ack
            case (q.mode)
              baro_port_pkg::MODE_ADC:  next_idx = baro_port_pkg::IDX_ADC_FIRST;   // [RL8]
              baro_port_pkg::MODE_CAL:  next_idx = baro_port_pkg::IDX_CAL_FIRST;   // [RL5]
              default:                  next_idx = baro_port_pkg::IDX_NONE;
            endcase
            next_byte  = pick(q.tx_word, next_idx);                           // [RL6]
            d.byte_idx = next_idx;
            d.sh       = next_byte;
            d.drive    = ~next_byte[7];
            d.st       = baro_port_pkg::ST_TX;
          end else begin
            d.st = baro_port_pkg::ST_CMD;
          end
        end
      end
      baro_port_pkg::ST_TX: begin
        if (scl_rise) begin
          d.cnt = q.cnt + 4'h1;
        end else if (scl_fall) begin
          if (q.cnt == baro_port_pkg::BITS_PER_BYTE) begin
            d.drive = 1'b0;                                                   // [RL9]
            d.st    = baro_port_pkg::ST_TX_ACK;
          end else begin
            d.sh    = {q.sh[6:0], 1'b0};
            d.drive = ~q.sh[6];
          end
        end
      end
      baro_port_pkg::ST_TX_ACK: begin
        if (scl_rise) begin
          // a not-acknowledge ends the read; the master then sends stop
          d.st = q.sda_sync[1] ? baro_port_pkg::ST_IGNORE                     // [RL9]
                               : baro_port_pkg::ST_TX_LOAD;
        end
      end
      baro_port_pkg::ST_TX_LOAD: begin
        if (scl_fall) begin
          // past the last valid byte the index saturates and zeros go out
          next_idx   = (q.byte_idx == 2'h3) ? 2'h3 : q.byte_idx + 2'h1;
          next_byte  = pick(q.tx_word, next_idx);                             // [RL6]
          d.byte_idx = next_idx;
          d.sh       = next_byte;
          d.drive    = ~next_byte[7];
          d.cnt      = 4'h0;
          d.st       = baro_port_pkg::ST_TX;
        end
      end
      baro_port_pkg::ST_IGNORE: begin
        d.drive = 1'b0;
      end
      default: begin
        d.st    = baro_port_pkg::ST_IDLE;
        d.drive = 1'b0;
      end
    endcase

    if (exec) begin
      if (q.sh == baro_port_pkg::CMD_RESET) begin                            // [RL3]
        // abandons any conversion and read state; reloads calibration storage
        d.busy         = 1'b0;
        d.corrupt      = 1'b0;
        d.result_valid = 1'b0;
        d.result       = '0;
        d.mode         = baro_port_pkg::MODE_NONE;
        d.tx_word      = '0;
        d.loaded       = 1'b1;                                                // [RL16]
        for (int w = 0; w < baro_port_pkg::CAL_WORDS; w++) begin              // [RL10]
          d.cal[w] = CAL_IMAGE[w];                                            // [RL11]
        end
        d.cal[baro_port_pkg::OFS_CHECK_CODE_WORD] =
          {CAL_IMAGE[baro_port_pkg::OFS_CHECK_CODE_WORD][15:4], CHECK_CODE};  // [RL12]
      end else if (q.sh == baro_port_pkg::CMD_ADC_READ) begin
        d.mode = baro_port_pkg::MODE_ADC;                                     // [RL8]
        if (q.busy) begin
          d.tx_word = '0;                                                     // [RL15]
          d.corrupt = 1'b1;
        end else begin
          d.tx_word      = q.result_valid ? q.result : '0;                    // [RL15]
          d.result_valid = 1'b0;
        end
      end else if (q.sh[7:4] == baro_port_pkg::CMD_CAL_HI && !q.sh[0]) begin
        d.mode    = baro_port_pkg::MODE_CAL;                                  // [RL5]
        // storage stays zero until the reset command has loaded it
        d.tx_word = {8'h00, q.cal[q.sh[3:1]]};                                // [RL13]
      end else if (q.sh[7:5] == baro_port_pkg::CMD_CONV_HI && !q.sh[0] &&
                   q.sh[3:1] <= baro_port_pkg::MAX_RATIO_CODE) begin          // [RL14]
        d.mode                    = baro_port_pkg::MODE_NONE;
        d.tx_word                 = '0;
        d.conv.start              = 1'b1;
        d.conv.temperature        = q.sh[4];
        d.conv.oversampling_ratio = q.sh[3:1];
        d.result_valid            = 1'b0;
        if (q.busy) begin
          d.corrupt = 1'b1;                                                   // [RL15]
        end
        d.busy = 1'b1;                                                        // [RL7]
      end
    end

    // framing overrides whatever the byte engine was doing
    if (bus_stop) begin                                                      // [RL1]
      d.st    = baro_port_pkg::ST_IDLE;
      d.drive = 1'b0;
    end else if (bus_start) begin                                            // [RL1]
      d.st    = baro_port_pkg::ST_ADDR;
      d.cnt   = 4'h0;
      d.drive = 1'b0;
    end
    // protocol select low parks the port; it never pulls the data line then
    if (!q.psel_sync[1]) begin
      d.st    = baro_port_pkg::ST_IDLE;
      d.drive = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = q.drive;
  assign conv_o   = q.conv;
  assign busy_o   = q.busy;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  chk_idle_no_drive: assert property (                                       // [RL1]
    (q.st == baro_port_pkg::ST_IDLE) && $past(q.st) == baro_port_pkg::ST_IDLE |-> !sda_oe_o)
    else $error("data line driven while port idle");
  chk_addr_ack_drive: assert property (                                      // [RL2]
    (q.st == baro_port_pkg::ST_ADDR_ACK) && scl_fall && addr_match && q.psel_sync[1]
      && !bus_start && !bus_stop |=> sda_oe_o && q.st == baro_port_pkg::ST_ACK_HOLD)
    else $error("matching address not acknowledged");
  chk_reset_clears: assert property (                                        // [RL3]
    exec && q.sh == baro_port_pkg::CMD_RESET |=> !busy_o && q.loaded && !q.result_valid)
    else $error("reset command did not clear conversion state");
  chk_conv_busy: assert property (                                           // [RL7]
    d.conv.start |=> busy_o && conv_o.start ##1 !conv_o.start)
    else $error("conversion start did not set busy");
  chk_bad_ratio_idle: assert property (                                      // [RL14]
    exec && q.sh[7:5] == baro_port_pkg::CMD_CONV_HI && q.sh[3:1] > baro_port_pkg::MAX_RATIO_CODE
      |=> !conv_o.start)
    else $error("out of range ratio started a conversion");
  chk_adc_mid_zero: assert property (                                        // [RL15]
    exec && q.sh == baro_port_pkg::CMD_ADC_READ && q.busy |=> q.tx_word == '0 && q.corrupt)
    else $error("result read during conversion not zero");
  chk_calmem_word: assert property (                                         // [RL13]
    exec && q.sh[7:4] == baro_port_pkg::CMD_CAL_HI && !q.sh[0]
      |=> q.tx_word[15:0] == $past(q.cal[q.sh[3:1]]) && q.mode == baro_port_pkg::MODE_CAL)
    else $error("memory read latched wrong word");
  chk_check_nibble: assert property (                                        // [RL12]
    q.loaded |-> q.cal[baro_port_pkg::OFS_CHECK_CODE_WORD][3:0] == CHECK_CODE
      && q.cal[baro_port_pkg::OFS_FACTORY_SETUP_WORD] == CAL_IMAGE[0])
    else $error("calibration storage differs from image");
  chk_tx_bit_hold: assert property (                                         // [RL6]
    q.st == baro_port_pkg::ST_TX && !scl_fall && !bus_stop && !bus_start && q.psel_sync[1]
      |=> $stable(sda_oe_o))
    else $error("data bit changed while clock not falling");
  chk_nack_ends: assert property (                                           // [RL9]
    q.st == baro_port_pkg::ST_TX_ACK && scl_rise && q.sda_sync[1] && q.psel_sync[1]
      && !bus_start && !bus_stop |=> q.st == baro_port_pkg::ST_IGNORE ##1 !sda_oe_o)
    else $error("not-acknowledge did not end the read");

  cov_calmem_read: cover property (
    q.mode == baro_port_pkg::MODE_CAL && q.st == baro_port_pkg::ST_TX_LOAD);
  cov_adc_read: cover property (
    q.mode == baro_port_pkg::MODE_ADC && q.byte_idx == 2'h2 && q.st == baro_port_pkg::ST_TX);
  cov_conv_done: cover property (q.busy && conv_done_i);
  cov_mid_read: cover property (exec && q.sh == baro_port_pkg::CMD_ADC_READ && q.busy);
  cov_overlap_conv: cover property (q.busy && d.conv.start);

endmodule // baro_cmd_port

// [include/baro_port_pkg.sv]
// constants and types for the two-wire command port of the pressure sensor
package baro_port_pkg;
  // bus address: fixed upper six bits, seventh bit is the inverted chip select level
  localparam logic [5:0] DEV_ADDR_HI     = 6'h3b;
  // command bytes
  localparam logic [7:0] CMD_RESET       = 8'h1e;
  localparam logic [7:0] CMD_ADC_READ    = 8'h00;
  localparam logic [3:0] CMD_CAL_HI      = 4'ha;
  localparam logic [2:0] CMD_CONV_HI     = 3'h2;
  localparam logic [2:0] MAX_RATIO_CODE  = 3'h4;
  // calibration memory word offsets
  localparam logic [2:0] OFS_FACTORY_SETUP_WORD = 3'h0;
  localparam logic [2:0] OFS_CAL_COEFFICIENT_1  = 3'h1;
  localparam logic [2:0] OFS_CAL_COEFFICIENT_6  = 3'h6;
  localparam logic [2:0] OFS_CHECK_CODE_WORD    = 3'h7;
  localparam int         CHECK_CODE_W    = 4;
  localparam int         CAL_WORDS       = 8;
  localparam int         CAL_WORD_W      = 16;
  localparam int         RESULT_W        = 24;
  // first byte index sent in a read, per read mode (index 3 and above sends zero)
  localparam logic [1:0] IDX_ADC_FIRST   = 2'h0;
  localparam logic [1:0] IDX_CAL_FIRST   = 2'h1;
  localparam logic [1:0] IDX_NONE        = 2'h3;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_ACK_HOLD = 4'h3,
    ST_CMD      = 4'h4,
    ST_CMD_ACK  = 4'h5,
    ST_TX       = 4'h6,
    ST_TX_ACK   = 4'h7,
    ST_TX_LOAD  = 4'h8,
    ST_IGNORE   = 4'h9
  } port_state_t;

  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_ADC  = 2'h1,
    MODE_CAL  = 2'h2
  } read_mode_t;

  typedef struct packed {
    logic       start;
    logic       temperature;
    logic [2:0] oversampling_ratio;
  } conv_req_t;

  typedef struct packed {
    logic [1:0]                           scl_sync;
    logic [1:0]                           sda_sync;
    logic [1:0]                           cs_sync;
    logic [1:0]                           psel_sync;
    logic                                 scl_prev;
    logic                                 sda_prev;
    port_state_t                          st;
    logic [3:0]                           cnt;
    logic [7:0]                           sh;
    logic                                 rd;
    logic                                 drive;
    read_mode_t                           mode;
    logic [1:0]                           byte_idx;
    logic [RESULT_W-1:0]                  tx_word;
    logic [RESULT_W-1:0]                  result;
    logic                                 result_valid;
    logic                                 busy;
    logic                                 corrupt;
    logic                                 loaded;
    logic [CAL_WORDS-1:0][CAL_WORD_W-1:0] cal;
    conv_req_t                            conv;
  } port_regs_t;
endpackage

// [verif/bus_master_model.sv]
// behavioural two-wire bus master that drives the command port from the far side
module bus_master_model (
  input  wire logic clock_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // five clocks a phase: the port needs four, one spare covers synchroniser skew
  localparam int PH = 5;

  // the data output only ever releases to the pull-up or pulls low
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic hold();
    repeat (PH) @(posedge clock_i);
  endtask

  // raises sda first so a repeated start also works from a low clock
  task automatic start_cond();
    sda_o <= 1'b1;
    hold();
    scl_o <= 1'b1;
    hold();
    sda_o <= 1'b0;
    hold();
    scl_o <= 1'b0;
    hold();
  endtask

  task automatic stop_cond();
    sda_o <= 1'b0;
    hold();
    scl_o <= 1'b1;
    hold();
    sda_o <= 1'b1;
    hold();
  endtask

  // the wire is sampled at the end of the high phase, where it has settled
  task automatic bit_io(input logic b, output logic r);
    sda_o <= b;
    hold();
    scl_o <= 1'b1;
    hold();
    r = sda_i;
    scl_o <= 1'b0;
    hold();
  endtask

  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // acknowledges every byte but the last, which gets a not-acknowledge
  task automatic read_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask
endmodule // bus_master_model

// [verif/test_pressure_sensor_i2c_command_port.sv]
// self-checking bench for the two-wire command port of the pressure sensor
module test_pressure_sensor_i2c_command_port;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0][15:0] CAL   = {16'h7e5a, 16'hc0f3, 16'h1234, 16'hfedc,
                                        16'h8001, 16'h00ff, 16'h5aa5, 16'hbeef};
  localparam logic [3:0]       CHECK = 4'h9;
  logic                        clock_i     = 1'b0;
  logic                        rst_n_i     = 1'b0;
  logic                        cs_pin      = 1'b1;
  logic                        ps_pin      = 1'b1;
  logic                        conv_done   = 1'b0;
  logic [23:0]                 conv_result = 24'h0;
  logic                        sda_o;
  logic                        sda_oe_o;
  logic                        busy_o;
  logic                        m_scl;
  logic                        m_sda;
  logic                        sda_w;
  baro_port_pkg::conv_req_t    conv_o;
  baro_port_pkg::conv_req_t    last_conv;
  int                          n_fail  = 0;
  int                          checks  = 0;
  int                          n_start = 0;

  // open drain with pull-up: either party may pull low
  assign sda_w = m_sda & (sda_oe_o ? sda_o : 1'b1);

  baro_cmd_port #(.CAL_IMAGE(CAL), .CHECK_CODE(CHECK)) i_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(m_scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .chip_select_pin_i(cs_pin),
    .protocol_select_pin_i(ps_pin), .conv_o(conv_o), .conv_done_i(conv_done),
    .conv_result_i(conv_result), .busy_o(busy_o));
  bus_master_model i_master (.clock_i(clock_i), .sda_i(sda_w), .scl_o(m_scl), .sda_o(m_sda));

  always #50 clock_i = ~clock_i;

  always @(posedge clock_i) begin
    if (conv_o.start === 1'b1) begin
      n_start++;
      last_conv = conv_o;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [7:0] adr(input logic rw);
    return {6'h3b, ~cs_pin, rw};
  endfunction

  task automatic cmd_msg(input logic [7:0] a8, input logic [7:0] cmd, input logic exp_ack);
    logic a;
    i_master.start_cond();
    i_master.write_byte(a8, a);
    check("address ack", a, exp_ack);
    if (a === 1'b1) begin
      i_master.write_byte(cmd, a);
      check("command ack", a, 1'b1);
    end
    i_master.stop_cond();
  endtask

  task automatic read_msg(input int n, output logic [23:0] v);
    logic       a;
    logic [7:0] b;
    v = 24'h0;
    i_master.start_cond();
    i_master.write_byte(adr(1'b1), a);
    check("read address ack", a, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_master.read_byte(i == n - 1, b);
      v = {v[15:0], b};
    end
    i_master.stop_cond();
  endtask

  task automatic done_pulse(input logic [23:0] res);
    conv_result <= res;
    conv_done   <= 1'b1;
    @(posedge clock_i);
    conv_done <= 1'b0;
    repeat (2) @(posedge clock_i);
    check("busy after done", busy_o, 1'b0);
  endtask

  task automatic t_cal_read();
    logic [23:0] v;
    cmd_msg(adr(1'b0), 8'ha2, 1'b1);
    read_msg(2, v);
    check("word before reset command", v, 24'h0);
    cmd_msg(adr(1'b0), 8'h1e, 1'b1);
    for (int w = 0; w < 8; w++) begin
      cmd_msg(adr(1'b0), {4'ha, w[2:0], 1'b0}, 1'b1);
      read_msg(2, v);
      check("cal word", v, (w == 7) ? {CAL[7][15:4], CHECK} : CAL[w]);
    end
  endtask

  // wrong low address bit first, then the strap flipped so the other address answers
  task automatic t_address();
    cmd_msg({6'h3b, cs_pin, 1'b0}, 8'h1e, 1'b0);
    cs_pin <= 1'b0;
    repeat (5) @(posedge clock_i);
    cmd_msg(8'hec, 8'h1e, 1'b0);
    cmd_msg(adr(1'b0), 8'h1e, 1'b1);
    cs_pin <= 1'b1;
    repeat (5) @(posedge clock_i);
    // protocol select low parks the port, so even the right address goes unanswered
    ps_pin <= 1'b0;
    repeat (5) @(posedge clock_i);
    cmd_msg(adr(1'b0), 8'h1e, 1'b0);
    ps_pin <= 1'b1;
    repeat (5) @(posedge clock_i);
  endtask

  task automatic t_convert();
    logic [23:0] v;
    logic [23:0] res;
    int          ns;
    for (int t = 0; t < 2; t++) begin
      for (int r = 0; r < 5; r++) begin
        ns  = n_start;
        res = {4'ha, t[3:0], 8'hc3, 5'h0, r[2:0]};
        cmd_msg(adr(1'b0), {3'h2, t[0], r[2:0], 1'b0}, 1'b1);
        check("start pulses", n_start - ns, 1);
        check("conv request", last_conv, {1'b1, t[0], r[2:0]});
        check("busy after command", busy_o, 1'b1);
        done_pulse(res);
        cmd_msg(adr(1'b0), 8'h00, 1'b1);
        read_msg(3, v);
        check("result", v, res);
        cmd_msg(adr(1'b0), 8'h00, 1'b1);
        read_msg(3, v);
        check("repeated result read", v, 24'h0);
      end
    end
    ns = n_start;
    cmd_msg(adr(1'b0), 8'h4a, 1'b1);
    check("no start for bad ratio", n_start - ns, 0);
    check("idle for bad ratio", busy_o, 1'b0);
  endtask

  task automatic t_overlap();
    logic [23:0] v;
    cmd_msg(adr(1'b0), 8'h48, 1'b1);
    cmd_msg(adr(1'b0), 8'h00, 1'b1);
    read_msg(3, v);
    check("read mid conversion", v, 24'h0);
    check("busy kept", busy_o, 1'b1);
    done_pulse(24'h123456);
    cmd_msg(adr(1'b0), 8'h00, 1'b1);
    read_msg(3, v);
    // stored bitwise inverted: the inverse of 24'h123456
    check("spoilt result", v, 24'hedcba9);
    cmd_msg(adr(1'b0), 8'h58, 1'b1);
    cmd_msg(adr(1'b0), 8'h1e, 1'b1);
    check("busy cleared by reset command", busy_o, 1'b0);
    cmd_msg(adr(1'b0), 8'h00, 1'b1);
    read_msg(3, v);
    check("no result after reset command", v, 24'h0);
  endtask

  // master walks away during the address ack, then clocks the port free
  task automatic t_recover();
    logic       r;
    logic [7:0] a8;
    a8 = adr(1'b0);
    i_master.start_cond();
    for (int i = 7; i >= 0; i--) i_master.bit_io(a8[i], r);
    repeat (5) @(posedge clock_i);
    check("ack held low", sda_oe_o, 1'b1);
    for (int i = 0; i < 10; i++) i_master.bit_io(1'b1, r);
    check("ack of filler byte", r, 1'b0);
    i_master.stop_cond();
    cmd_msg(adr(1'b0), 8'h1e, 1'b1);
    check("data released", sda_oe_o, 1'b0);
  endtask

  initial begin
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    t_cal_read();
    t_address();
    t_convert();
    t_overlap();
    t_recover();
    end_sim();
  end

  // about three times the expected run length
  initial begin
    #(100 * 100000);
    n_fail++;
    end_sim();
  end
endmodule // test_pressure_sensor_i2c_command_port
